// file: src/dvz_top.v
// dvz_top.v: volume, de-emphasis select and zero/full-scale flag
// assumes: controls are plain register bit inputs, data synchronous
`timescale 1ns/1ps
`include "dvz_defs.vh"
module dvz_top (
    input wire ref_clk_in,
    input wire srst_in,
    input wire power_down_pin_n_in,
    input wire fs_tick_in,
    input wire bit_tick_in,
    input wire clock_stopped_in,
    input wire soft_reset_bit_in,
    input wire power_on_bit_in,
    input wire [1:0] data_mode_in,
    input wire [2:0] pcm_speed_in,
    input wire [1:0] deemphasis_select_in,
    input wire [1:0] ramp_step_time_in,
    input wire left_vol_we_in,
    input wire right_vol_we_in,
    input wire [7:0] vol_wdata_in,
    input wire fullscale_flag_select_in,
    input wire flag_polarity_invert_in,
    input wire zero_left_en_in,
    input wire zero_right_en_in,
    input wire volume_bypass_select_in,
    input wire fullscale_detect_time_in,
    input wire left_data_zero_in,
    input wire right_data_zero_in,
    input wire dsd_left_bit_in,
    input wire dsd_right_bit_in,
    output reg [7:0] left_volume_level_out,
    output reg [7:0] right_volume_level_out,
    output reg [7:0] left_gain_out,
    output reg [7:0] right_gain_out,
    output reg left_mute_out,
    output reg right_mute_out,
    output reg [2:0] deemph_curve_out,
    output reg left_fullscale_flag_out,
    output reg right_fullscale_flag_out,
    output reg zero_flag_out,
    output reg flag_output_pin_out
);
    // local state
    reg [7:0] left_volume_level_q; // written level, left
    reg [7:0] right_volume_level_q; // written level, right
    reg [3:0] imm_cnt_q; // ticks since soft reset release
    reg run_q; // soft reset released
    reg [2:0] clr_cnt_q; // zero clear delay after release
    reg zero_hold_q; // zero flag forced during reset window
    reg [16:0] zero_cnt_q; // zero persistence count
    reg [8:0] fs_cnt_l_q; // full-scale count, left
    reg [8:0] fs_cnt_r_q; // full-scale count, right
    reg dsd_l_last_q; // previous left dsd bit
    reg dsd_r_last_q; // previous right dsd bit
    wire [7:0] left_ramp; // ramped level, left
    wire [7:0] right_ramp; // ramped level, right
    reg [4:0] step_len; // ticks per code step
    reg [16:0] zero_need; // zero detection time
    reg [8:0] fs_need; // full-scale detection time
    reg zero_now; // selected channels all zero
    wire is_pcm; // pcm mode
    wire is_dop; // dop mode
    wire immediate; // inside immediate-apply window
    wire fs_tick; // full-scale count enable
    wire dsd_bypass; // volume bypass in dsd
    reg flag_src; // flag before polarity
    reg pin_next; // next pin level
    reg [7:0] left_gain_d; // next left gain
    reg [7:0] right_gain_d; // next right gain

    assign is_pcm = (data_mode_in == `DVZ_MODE_PCM);
    assign is_dop = (data_mode_in == `DVZ_MODE_DOP);
    assign immediate = run_q && (imm_cnt_q < `DVZ_IMM_TICKS);
    assign fs_tick = is_dop ? fs_tick_in : bit_tick_in;
    assign dsd_bypass = (data_mode_in == `DVZ_MODE_DSD) &&
                        volume_bypass_select_in;

    // written levels; only power-down or reset restore 0 dB
    always @(posedge ref_clk_in) begin
        if (srst_in || !power_down_pin_n_in) begin
            left_volume_level_q <= `DVZ_VOL_RESET;
            right_volume_level_q <= `DVZ_VOL_RESET;
        end else begin
            // no mode input here, so values survive switches
            if (left_vol_we_in)
                left_volume_level_q <= vol_wdata_in;
            if (right_vol_we_in)
                right_volume_level_q <= vol_wdata_in;
        end
    end

    // step period decode
    always @* begin
        case (ramp_step_time_in)
            2'h0: step_len = `DVZ_STEP_00;
            2'h1: step_len = `DVZ_STEP_01;
            2'h2: step_len = `DVZ_STEP_10;
            default: step_len = `DVZ_STEP_11;
        endcase
    end

    // one ramp per channel, same tick in every mode
    dvz_ramp u_ramp_l (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in || !power_down_pin_n_in),
        .tick_in(fs_tick_in),
        .step_len_in(step_len),
        .immediate_in(immediate),
        .hold_in(!run_q),
        .target_in(left_volume_level_q),
        .level_out(left_ramp)
    );
    dvz_ramp u_ramp_r (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in || !power_down_pin_n_in),
        .tick_in(fs_tick_in),
        .step_len_in(step_len),
        .immediate_in(immediate),
        .hold_in(!run_q),
        .target_in(right_volume_level_q),
        .level_out(right_ramp)
    );

    // soft reset release tracking for immediate and clear windows
    always @(posedge ref_clk_in) begin
        if (srst_in || !power_down_pin_n_in) begin
            run_q <= 1'b0;
            imm_cnt_q <= 4'h0;
            clr_cnt_q <= 3'h0;
            zero_hold_q <= 1'b1;
        end else if (!soft_reset_bit_in) begin
            run_q <= 1'b0;
            imm_cnt_q <= 4'h0;
            clr_cnt_q <= 3'h0;
            zero_hold_q <= 1'b1;
        end else begin
            run_q <= 1'b1;
            if (fs_tick_in && imm_cnt_q < `DVZ_IMM_TICKS)
                imm_cnt_q <= imm_cnt_q + 4'h1;
            if (fs_tick_in && zero_hold_q) begin
                // release after 4 to 5 ticks
                if (clr_cnt_q == `DVZ_RST_CLR_TICKS)
                    zero_hold_q <= 1'b0;
                else
                    clr_cnt_q <= clr_cnt_q + 3'h1;
            end
        end
    end

    // zero detection time and monitor
    always @* begin
        if (!is_pcm)
            zero_need = `DVZ_ZERO_DSD;
        else if (pcm_speed_in == `DVZ_SPD_OCT ||
                 pcm_speed_in == `DVZ_SPD_HEX)
            zero_need = `DVZ_ZERO_FAST;
        else
            zero_need = `DVZ_ZERO_PCM;
        // all selected channels zero, none selected never
        zero_now = (zero_left_en_in || zero_right_en_in) &&
                   (!zero_left_en_in || left_data_zero_in) &&
                   (!zero_right_en_in || right_data_zero_in);
    end

    // zero persistence counter, cleared by nonzero data on a selected channel
    always @(posedge ref_clk_in) begin
        if (srst_in || !zero_now || dsd_bypass) begin
            zero_cnt_q <= {`DVZ_ZERO_W{1'b0}};
        end else if (fs_tick_in && zero_cnt_q < zero_need) begin
            zero_cnt_q <= zero_cnt_q + 17'h00001;
        end
    end

    // full-scale detect time select
    always @* begin
        if (is_dop)
            fs_need = fullscale_detect_time_in ? `DVZ_FS_DOP_SHORT :
                      `DVZ_FS_DOP_LONG;
        else
            fs_need = fullscale_detect_time_in ? `DVZ_FS_SHORT :
                      `DVZ_FS_LONG;
    end

    // full-scale: count ticks of unchanged dsd bit per channel
    always @(posedge ref_clk_in) begin
        if (srst_in || is_pcm || !run_q) begin
            fs_cnt_l_q <= 9'h000;
            fs_cnt_r_q <= 9'h000;
            dsd_l_last_q <= 1'b0;
            dsd_r_last_q <= 1'b0;
            left_fullscale_flag_out <= 1'b0;
            right_fullscale_flag_out <= 1'b0;
        end else if (fs_tick) begin
            dsd_l_last_q <= dsd_left_bit_in;
            dsd_r_last_q <= dsd_right_bit_in;
            // toggle releases detection
            if (dsd_left_bit_in != dsd_l_last_q)
                fs_cnt_l_q <= 9'h000;
            else if (fs_cnt_l_q < fs_need)
                fs_cnt_l_q <= fs_cnt_l_q + 9'h001;
            if (dsd_right_bit_in != dsd_r_last_q)
                fs_cnt_r_q <= 9'h000;
            else if (fs_cnt_r_q < fs_need)
                fs_cnt_r_q <= fs_cnt_r_q + 9'h001;
            left_fullscale_flag_out <= (dsd_left_bit_in == dsd_l_last_q) &&
                                       (fs_cnt_l_q + 9'h001 >= fs_need);
            right_fullscale_flag_out <= (dsd_right_bit_in == dsd_r_last_q) &&
                                        (fs_cnt_r_q + 9'h001 >= fs_need);
        end
    end

    // effective gain with dsd low-code mute
    always @* begin
        left_gain_d = left_ramp;
        right_gain_d = right_ramp;
        if (!is_pcm && left_ramp <= `DVZ_VOL_DSD_MUTE_MAX)
            left_gain_d = `DVZ_VOL_MUTE;
        if (!is_pcm && right_ramp <= `DVZ_VOL_DSD_MUTE_MAX)
            right_gain_d = `DVZ_VOL_MUTE;
    end

    // flag pin source select
    always @* begin
        if (fullscale_flag_select_in) begin
            if (is_pcm)
                flag_src = 1'b0;
            else if (zero_left_en_in ^ zero_right_en_in)
                flag_src = zero_left_en_in ? left_fullscale_flag_out :
                           right_fullscale_flag_out;
            else
                flag_src = left_fullscale_flag_out ||
                           right_fullscale_flag_out;
        end else if (dsd_bypass) begin
            flag_src = 1'b1;
        end else begin
            flag_src = zero_hold_q || (zero_cnt_q >= zero_need);
        end
        pin_next = flag_src ^ flag_polarity_invert_in;
    end

    // registered outputs
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            left_volume_level_out <= `DVZ_VOL_RESET;
            right_volume_level_out <= `DVZ_VOL_RESET;
            left_gain_out <= `DVZ_VOL_RESET;
            right_gain_out <= `DVZ_VOL_RESET;
            left_mute_out <= 1'b0;
            right_mute_out <= 1'b0;
            deemph_curve_out <= 3'h0;
            zero_flag_out <= 1'b1;
            flag_output_pin_out <= 1'b1 ^ flag_polarity_invert_in;
        end else begin
            left_volume_level_out <= left_volume_level_q;
            right_volume_level_out <= right_volume_level_q;
            left_gain_out <= left_gain_d;
            right_gain_out <= right_gain_d;
            left_mute_out <= (left_gain_d == `DVZ_VOL_MUTE);
            right_mute_out <= (right_gain_d == `DVZ_VOL_MUTE);
            // stored select untouched by mode
            deemph_curve_out <= 3'h0;
            if (is_pcm && pcm_speed_in == `DVZ_SPD_NORMAL) begin
                case (deemphasis_select_in)
                    `DVZ_DSEL_441: deemph_curve_out[`DVZ_CRV_441] <= 1'b1;
                    `DVZ_DSEL_48: deemph_curve_out[`DVZ_CRV_48] <= 1'b1;
                    `DVZ_DSEL_32: deemph_curve_out[`DVZ_CRV_32] <= 1'b1;
                    default: deemph_curve_out <= 3'h0;
                endcase
            end
            zero_flag_out <= zero_hold_q || (zero_cnt_q >= zero_need);
            if (clock_stopped_in)
                flag_output_pin_out <= (zero_hold_q ||
                    (zero_cnt_q >= zero_need)) ^
                    flag_polarity_invert_in;
            else if (power_on_bit_in)
                flag_output_pin_out <= pin_next;
            // power bit off: pin holds
        end
    end
endmodule

// file: src/dvz_defs.vh
// dvz_defs.vh: constants for the volume, de-emphasis and zero-detect block
// assumes: included by bare name from every design file of the block
`ifndef DVZ_DEFS_VH
`define DVZ_DEFS_VH
// de-emphasis select codes
`define DVZ_DSEL_441 2'h0
`define DVZ_DSEL_OFF 2'h1
`define DVZ_DSEL_48 2'h2
`define DVZ_DSEL_32 2'h3
// one-hot de-emphasis curve output bits
`define DVZ_CRV_441 2'd0
`define DVZ_CRV_48 2'd1
`define DVZ_CRV_32 2'd2
// volume codes
`define DVZ_VOL_RESET 8'hff
`define DVZ_VOL_MUTE 8'h00
`define DVZ_VOL_DSD_MUTE_MAX 8'h02
// data modes
`define DVZ_MODE_PCM 2'h0
`define DVZ_MODE_DSD 2'h1
`define DVZ_MODE_DOP 2'h2
// pcm speed codes
`define DVZ_SPD_NORMAL 3'h0
`define DVZ_SPD_DOUBLE 3'h1
`define DVZ_SPD_QUAD 3'h2
`define DVZ_SPD_OCT 3'h3
`define DVZ_SPD_HEX 3'h4
// ramp step periods in sample ticks
`define DVZ_STEP_00 5'h10
`define DVZ_STEP_01 5'h08
`define DVZ_STEP_10 5'h02
`define DVZ_STEP_11 5'h01
// immediate-apply window after reset release, in sample ticks
`define DVZ_IMM_TICKS 4'ha
// zero detection times in sample ticks
`define DVZ_ZERO_PCM 17'h02000
`define DVZ_ZERO_FAST 17'h10000
`define DVZ_ZERO_DSD 17'h01000
`define DVZ_ZERO_W 17
// zero flag clear delay after soft reset release (4 to 5 ticks)
`define DVZ_RST_CLR_TICKS 3'h4
// full-scale detect times in bit ticks; the DOP ones count sample ticks
`define DVZ_FS_LONG 9'h100
`define DVZ_FS_SHORT 9'h080
`define DVZ_FS_DOP_LONG 9'h010
`define DVZ_FS_DOP_SHORT 9'h008
`endif

// file: src/dvz_ramp.v
// dvz_ramp.v: one channel of soft-ramped volume
// assumes: sample tick is a one-cycle enable from the sample clock divider
`timescale 1ns/1ps
`include "dvz_defs.vh"
module dvz_ramp (
    input wire ref_clk_in,
    input wire srst_in,
    input wire tick_in,
    input wire [4:0] step_len_in,
    input wire immediate_in,
    input wire hold_in,
    input wire [7:0] target_in,
    output reg [7:0] level_out
);
    reg [4:0] cnt_q; // ticks into current step

    // walk one code per step toward target, redirecting on new target
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            level_out <= `DVZ_VOL_RESET;
            cnt_q <= 5'h00;
        end else if (hold_in) begin
            // level stays put while in reset; target applies after
            cnt_q <= 5'h00;
        end else if (immediate_in) begin
            level_out <= target_in;
            cnt_q <= 5'h00;
        end else if (level_out == target_in) begin
            cnt_q <= 5'h00;
        end else if (tick_in) begin
            if (cnt_q + 5'h01 >= step_len_in) begin
                cnt_q <= 5'h00;
                // one code per step period
                if (level_out < target_in)
                    level_out <= level_out + 8'h01;
                else
                    level_out <= level_out - 8'h01;
            end else begin
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end
endmodule

// file: verification/dvz_top_asserts.sv
// dvz_top_asserts.sv: port-level timing checks for dvz_top
// assumes: bound to dvz_top, one clock, sync reset high
`timescale 1ns/1ps
module dvz_top_asserts (
    input logic ref_clk_in,
    input logic srst_in,
    input logic power_down_pin_n_in,
    input logic clock_stopped_in,
    input logic soft_reset_bit_in,
    input logic power_on_bit_in,
    input logic [1:0] data_mode_in,
    input logic [2:0] pcm_speed_in,
    input logic [1:0] deemphasis_select_in,
    input logic left_vol_we_in,
    input logic [7:0] vol_wdata_in,
    input logic fullscale_flag_select_in,
    input logic flag_polarity_invert_in,
    input logic zero_left_en_in,
    input logic volume_bypass_select_in,
    input logic left_data_zero_in,
    input logic [7:0] left_volume_level_out,
    input logic [7:0] right_volume_level_out,
    input logic [7:0] left_gain_out,
    input logic [2:0] deemph_curve_out,
    input logic left_fullscale_flag_out,
    input logic zero_flag_out,
    input logic flag_output_pin_out
);
    default clocking dck @(posedge ref_clk_in);
    endclocking
    default disable iff (srst_in);
    // curve choice follows the select code in pcm normal speed only
    a_curve_sel: assert property (
        (data_mode_in == 2'h0 && pcm_speed_in == 3'h0 &&
        deemphasis_select_in == 2'h0)[*3] |-> deemph_curve_out == 3'h1)
        else $error("44.1 curve not chosen");
    a_curve_off: assert property (
        (deemphasis_select_in == 2'h1 || data_mode_in != 2'h0 ||
        pcm_speed_in != 3'h0)[*3] |-> deemph_curve_out == 3'h0)
        else $error("de-emphasis not off");
    // a write shows on the level output two edges later
    a_level_write: assert property (
        left_vol_we_in && power_down_pin_n_in ##1 power_down_pin_n_in &&
        !left_vol_we_in ##1 power_down_pin_n_in
        |-> left_volume_level_out == $past(vol_wdata_in, 2))
        else $error("left level not written");
    a_powerdown_levels: assert property (
        (!power_down_pin_n_in)[*3] |-> left_volume_level_out == 8'hff
        && right_volume_level_out == 8'hff)
        else $error("power-down did not reset levels");
    a_zero_srst: assert property (
        (!soft_reset_bit_in)[*3] |-> zero_flag_out)
        else $error("zero flag low in soft reset");
    a_zero_clear: assert property (
        soft_reset_bit_in && zero_left_en_in && $fell(left_data_zero_in)
        |-> ##[1:3] !zero_flag_out)
        else $error("zero flag not cleared");
    a_fs_pcm: assert property (
        (data_mode_in == 2'h0)[*2] |-> !left_fullscale_flag_out)
        else $error("full-scale flag in pcm");
    // pin mirrors the zero flag with the chosen polarity
    a_pin_zero: assert property (
        (!fullscale_flag_select_in && power_on_bit_in &&
        !volume_bypass_select_in && $stable(zero_flag_out) &&
        $stable(flag_polarity_invert_in))[*3]
        |-> flag_output_pin_out == (zero_flag_out ^ flag_polarity_invert_in))
        else $error("pin does not show zero flag");
    a_pin_pcm_fs: assert property (
        (fullscale_flag_select_in && data_mode_in == 2'h0 &&
        power_on_bit_in && !clock_stopped_in &&
        $stable(flag_polarity_invert_in))[*3]
        |-> flag_output_pin_out == flag_polarity_invert_in)
        else $error("pin not inactive in pcm");
    a_pin_hold: assert property (
        (!power_on_bit_in && !clock_stopped_in)[*2]
        |-> $stable(flag_output_pin_out))
        else $error("pin moved in standby");
    a_bypass_pin: assert property (
        (data_mode_in == 2'h1 && volume_bypass_select_in &&
        !fullscale_flag_select_in && power_on_bit_in && !clock_stopped_in &&
        $stable(flag_polarity_invert_in))[*3]
        |-> flag_output_pin_out == !flag_polarity_invert_in)
        else $error("bypass pin not active");
    c_zero: cover property (soft_reset_bit_in && zero_flag_out);
    c_ramp: cover property ($fell(left_gain_out[0]));
    c_fs: cover property (left_fullscale_flag_out);
endmodule
bind dvz_top dvz_top_asserts chk_u (.*);

// file: verification/dvz_src_model.sv
// dvz_src_model.sv: sample source: sample and bit ticks, dsd data bits
// assumes: one clock, sync reset high; hold makes a full-scale run
`timescale 1ns/1ps
module dvz_src_model #(
    parameter int FS_DIV = 2 // cycles per sample tick
) (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic hold_in,
    output logic fs_tick_out,
    output logic bit_tick_out,
    output logic dsd_left_out,
    output logic dsd_right_out
);
    int cnt_q; // sample divider
    // pulses and data change just after the edge, like the real source
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            cnt_q <= 0;
            fs_tick_out <= 1'b0;
            bit_tick_out <= 1'b0;
            dsd_left_out <= 1'b0;
            dsd_right_out <= 1'b1;
        end else begin
            cnt_q <= (cnt_q == FS_DIV - 1) ? 0 : cnt_q + 1;
            fs_tick_out <= (cnt_q == FS_DIV - 1);
            bit_tick_out <= ~bit_tick_out;
            // toggling data unless a constant run is asked for
            if (bit_tick_out) begin
                dsd_left_out <= hold_in | ~dsd_left_out;
                dsd_right_out <= hold_in | ~dsd_right_out;
            end
        end
    end
endmodule

// file: verification/tb_dac_volume_deemph_zero_detect.sv
// tb_dac_volume_deemph_zero_detect.sv: self-checking bench for dvz_top
// assumes: dvz_src_model makes the ticks; inputs move on falling edges
`timescale 1ns/1ps
module tb_dac_volume_deemph_zero_detect;
    localparam int FSD = 2; // cycles per sample tick
    logic ref_clk_in = 0, srst_in = 1, power_down_pin_n_in = 1;
    logic clock_stopped_in = 0, soft_reset_bit_in = 0, power_on_bit_in = 1;
    logic left_vol_we_in = 0, right_vol_we_in = 0, dsd_hold = 0;
    logic fullscale_flag_select_in = 0, flag_polarity_invert_in = 0;
    logic zero_left_en_in = 1, zero_right_en_in = 0;
    logic volume_bypass_select_in = 0, fullscale_detect_time_in = 0;
    logic left_data_zero_in = 0, right_data_zero_in = 0;
    logic [1:0] data_mode_in = 0, deemphasis_select_in = 1;
    logic [1:0] ramp_step_time_in = 0;
    logic [2:0] pcm_speed_in = 0;
    logic [7:0] vol_wdata_in = 0;
    wire fs_tick_in, bit_tick_in, dsd_left_bit_in, dsd_right_bit_in;
    wire [7:0] left_volume_level_out, right_volume_level_out;
    wire [7:0] left_gain_out, right_gain_out;
    wire [2:0] deemph_curve_out;
    wire left_mute_out, right_mute_out, left_fullscale_flag_out;
    wire right_fullscale_flag_out, zero_flag_out, flag_output_pin_out;
    int error_cnt = 0, checked = 0, n;
    int step_tab [4] = '{16, 8, 2, 1}; // ticks per code step
    logic [2:0] crv_tab [4] = '{3'h1, 3'h0, 3'h2, 3'h4}; // one-hot curve
    always #2.5 ref_clk_in = ~ref_clk_in;
    dvz_src_model #(.FS_DIV(FSD)) src_u (.ref_clk_in(ref_clk_in),
        .srst_in(srst_in), .hold_in(dsd_hold), .fs_tick_out(fs_tick_in),
        .bit_tick_out(bit_tick_in), .dsd_left_out(dsd_left_bit_in),
        .dsd_right_out(dsd_right_bit_in));
    dvz_top dut_u (.*);
    task automatic chk(input string nm, input logic [31:0] seen, want);
        checked++;
        if (seen !== want) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", nm, want, seen);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge ref_clk_in);
    endtask
    // one-cycle level write to left (rgt=0) or right
    task automatic wr(input logic rgt, input logic [7:0] v);
        left_vol_we_in = !rgt;
        right_vol_we_in = rgt;
        vol_wdata_in = v;
        cyc(1);
        left_vol_we_in = 0;
        right_vol_we_in = 0;
    endtask
    // bounded wait for the left ramp, n holds the cycles taken
    task automatic wait_l(input logic [7:0] v, input int lim);
        for (n = 0; left_gain_out !== v && n < lim; n++) cyc(1);
        if (n >= lim) begin
            chk("ramp_wait", 0, 1);
            close_out();
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        cyc(20);
        srst_in = 0;
        wr(0, 8'h40);
        cyc(4);
        chk("lvl_l", left_volume_level_out, 8'h40);
        chk("lvl_r", right_volume_level_out, 8'hff);
        chk("gain_held", left_gain_out, 8'hff);
        chk("zf_srst", zero_flag_out, 1);
        soft_reset_bit_in = 1;
        cyc(3 * FSD);
        chk("zf_early", zero_flag_out, 1);
        wr(1, 8'h20);
        cyc(4 * FSD);
        chk("zf_clr", zero_flag_out, 0);
        chk("imm_l", left_gain_out, 8'h40);
        chk("imm_r", right_gain_out, 8'h20);
        cyc(12 * FSD);
        // eight-code ramps at each step setting, timed
        for (int i = 0; i < 4; i++) begin
            ramp_step_time_in = 2'(i);
            wr(0, 8'h38 - 8'(8 * i));
            wait_l(8'h38 - 8'(8 * i), 20 * step_tab[i] * FSD);
            chk("ramp_t", n >= 7 * step_tab[i] * FSD &&
                n <= 9 * step_tab[i] * FSD + 6, 1);
        end
        wr(0, 8'h10);
        cyc(4 * FSD);
        chk("mid", left_gain_out < 8'h20 &&
            left_gain_out > 8'h10, 1);
        wr(0, 8'h18);
        wait_l(8'h18, 40 * FSD);
        cyc(4 * FSD);
        chk("redirect", left_gain_out, 8'h18);
        wr(0, 8'h02);
        wait_l(8'h02, 40 * FSD);
        chk("pcm_02", left_mute_out, 0);
        data_mode_in = 1;
        cyc(4);
        chk("dsd_02", {left_mute_out, left_gain_out}, 9'h100);
        chk("mute_r", right_mute_out, 0);
        data_mode_in = 0;
        cyc(4);
        chk("kept", {left_volume_level_out, left_gain_out},
            16'h0202);
        wr(0, 8'h00);
        wait_l(8'h00, 10 * FSD);
        chk("mute_00", left_mute_out, 1);
        for (int i = 0; i < 4; i++) begin
            deemphasis_select_in = 2'(i);
            cyc(3);
            chk("curve", deemph_curve_out, crv_tab[i]);
        end
        pcm_speed_in = 1;
        cyc(3);
        chk("crv_dbl", deemph_curve_out, 0);
        pcm_speed_in = 0;
        data_mode_in = 1;
        cyc(3);
        chk("crv_dsd", deemph_curve_out, 0);
        data_mode_in = 0;
        cyc(3);
        chk("crv_back", deemph_curve_out, 3'h4);
        // left silent, right busy but not watched
        left_data_zero_in = 1;
        cyc((8192 - 4) * FSD);
        chk("zf_pcm_lo", zero_flag_out, 0);
        cyc(8 * FSD);
        chk("zf_pcm", zero_flag_out, 1);
        chk("pin_zf", flag_output_pin_out, 1);
        left_data_zero_in = 0;
        cyc(3);
        chk("zf_gone", zero_flag_out, 0);
        zero_right_en_in = 1;
        left_data_zero_in = 1;
        cyc(8200 * FSD);
        chk("zf_both", zero_flag_out, 0);
        zero_right_en_in = 0;
        data_mode_in = 1;
        cyc((4096 - 4) * FSD);
        chk("zf_dsd_lo", zero_flag_out, 0);
        cyc(8 * FSD);
        chk("zf_dsd", zero_flag_out, 1);
        flag_polarity_invert_in = 1;
        cyc(3);
        chk("pin_inv", flag_output_pin_out, 0);
        power_on_bit_in = 0;
        left_data_zero_in = 0;
        cyc(4);
        chk("pin_hold", flag_output_pin_out, 0);
        clock_stopped_in = 1;
        cyc(3);
        chk("pin_stop", flag_output_pin_out, 1);
        {clock_stopped_in, power_on_bit_in, flag_polarity_invert_in} = 3'h2;
        volume_bypass_select_in = 1;
        cyc(3);
        chk("pin_bypass", flag_output_pin_out, 1);
        volume_bypass_select_in = 0;
        fullscale_flag_select_in = 1;
        dsd_hold = 1;
        cyc(400);
        chk("fs_lo", left_fullscale_flag_out, 0);
        cyc(200);
        chk("fs_set", left_fullscale_flag_out, 1);
        chk("fs_set_r", right_fullscale_flag_out, 1);
        chk("pin_fs", flag_output_pin_out, 1);
        dsd_hold = 0;
        cyc(8);
        chk("fs_clr", left_fullscale_flag_out, 0);
        chk("fs_clr_r", right_fullscale_flag_out, 0);
        // dop mode, short detect time counted in frame ticks
        data_mode_in = 2;
        fullscale_detect_time_in = 1;
        dsd_hold = 1;
        cyc(12);
        chk("fs_dop_lo", left_fullscale_flag_out, 0);
        cyc(12);
        chk("fs_dop", left_fullscale_flag_out, 1);
        dsd_hold = 0;
        flag_polarity_invert_in = 1;
        data_mode_in = 0;
        cyc(4);
        chk("pin_pcm_fs", flag_output_pin_out, 1);
        power_down_pin_n_in = 0;
        cyc(3);
        chk("powerdown", {left_volume_level_out, right_volume_level_out},
            16'hffff);
        close_out();
    end
endmodule
